// *** pkg/spi_fifo_pkg.sv ***
// constants, register map and state codes for the fifo spi block
package spi_fifo_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int QUEUE_DEPTH = 8;
  localparam int QUEUE_CW = 4;
  localparam int BIT_CW = 5;

  localparam logic [2:0] OFF_CTRL1 = 3'h0;
  localparam logic [2:0] OFF_CTRL2 = 3'h1;
  localparam logic [2:0] OFF_BAUD = 3'h2;
  localparam logic [2:0] OFF_STATUS = 3'h3;
  localparam logic [2:0] OFF_DATA_HIGH = 3'h4;
  localparam logic [2:0] OFF_DATA_LOW = 3'h5;
  localparam logic [2:0] OFF_CLK_GATE = 3'h6;

  localparam int C1_LSB_FIRST = 0;
  localparam int C1_SEL_OUT_EN = 1;
  localparam int C1_PHASE = 2;
  localparam int C1_IDLE_LEVEL = 3;
  localparam int C1_MASTER = 4;
  localparam int C1_SYS_EN = 6;

  localparam int C2_SINGLE_WIRE = 0;
  localparam int C2_HALT_WAIT = 1;
  localparam int C2_BIDIR_OE = 3;
  localparam int C2_FAULT_EN = 4;
  localparam int C2_WORD16 = 6;
  localparam int C2_FIFO_EN = 7;

  localparam int ST_RX_READY = 0;
  localparam int ST_TX_ROOM = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_RXQ_FULL = 3;
  localparam int ST_TXQ_FULL = 4;
  localparam int ST_RXQ_OVR = 5;

  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic GATE_RST = 1'b1;

  localparam logic [BIT_CW-1:0] BITS_SHORT = 5'h08;
  localparam logic [BIT_CW-1:0] BITS_LONG = 5'h10;
  localparam logic [QUEUE_CW-1:0] LIMIT_SINGLE = 4'h1;
  localparam logic [QUEUE_CW-1:0] LIMIT_BYTES = 4'h8;
  localparam logic [QUEUE_CW-1:0] LIMIT_WORDS = 4'h4;

  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_SHIFT = 2'b01,
    XFER_FINISH = 2'b10
  } xfer_state_t;
endpackage

// *** pkg/spi_queue_if.sv ***
// queue port bundle between the spi core and its queues
`timescale 1ns/1ps
interface spi_queue_if #(parameter int W = 16, parameter int CW = 4);
  logic push;
  logic [W-1:0] push_data;
  logic pop;
  logic flush;
  logic [CW-1:0] limit;
  logic [W-1:0] head;
  logic [CW-1:0] count;
  logic full;
  logic empty;
  modport store(input push, push_data, pop, flush, limit, output head, count, full, empty);
  modport user(output push, push_data, pop, flush, limit, input head, count, full, empty);
endinterface

// *** rtl/spi_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spi_sync #(parameter int W = 4) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  if (W < 1) begin : g_bad_width
    $error("spi_sync width must be at least one");
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '1;
      sync_o <= '1;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

// *** rtl/spi_queue.sv ***
// word queue with a run-time fill limit
`timescale 1ns/1ps
module spi_queue #(parameter int WIDTH = 16, parameter int DEPTH = 8) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // module clock enable
  input wire logic en_i,
  // queue port
  spi_queue_if.store q
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || $bits(q.head) != WIDTH || $bits(q.count) != CW) begin : g_bad
    $error("spi_queue depth must be a power of two and match the port");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic do_push;
  logic do_pop;

  assign q.full = count_reg >= q.limit;
  assign q.empty = count_reg == '0;
  assign q.head = mem_reg[rd_ptr_reg];
  assign q.count = count_reg;
  assign do_push = en_i && q.push && !q.full && !q.flush;
  assign do_pop = en_i && q.pop && !q.empty && !q.flush;

  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= q.push_data;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (en_i && q.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// *** rtl/spi_fifo_ctrl.sv ***
// spi master/slave core with queues, pin routing and low-power control
//
// Behaviour
// - clock gate bit set after every reset
// - wait mode: run, or halt clock generation
// - halted master freezes; slave keeps shifting
// - light stop: master pauses, slave continues
// - deep stop disables, registers return reset
// - master starts transfers, shift registers exchange
// - slave takes part only while selected
// - load at start, store after 8/16 bits
// - queue mode: eight bytes each, flags
// - master drives clock and data out
// - slave clocked by pin, drives data out
// - disabled: all four pins released
// - single-wire master: shared line on mosi
// - single-wire slave: mosi pin released
// - single-wire slave: shared line on miso
// - single-wire master: miso pin released
// - select pin role by mode and enables
// - disable forces idle, clears status flags
// - clock idle level shared by both ends
`timescale 1ns/1ps
module spi_fifo_ctrl (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // power modes
  input wire logic wait_mode_i,
  input wire logic stop_light_i,
  input wire logic stop_deep_i,
  // serial clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  // master-out slave-in pin
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  // master-in slave-out pin
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  // select pin
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe_n_o,
  // pin ownership: sck, mosi, miso, select
  output logic [3:0] pin_owned_o
);
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] baud_reg;
  logic clk_gate_reg;
  logic [7:0] tx_high_reg;
  logic fault_reg;
  logic overrun_reg;
  logic [7:0] baud_cnt_reg;
  logic half_reg;
  logic sck_reg;
  logic out_bit_reg;
  logic ss_out_reg;
  logic [15:0] tx_sr_reg;
  logic [15:0] rx_sr_reg;
  logic [4:0] bit_cnt_reg;
  logic sck_d_reg;
  spi_fifo_pkg::xfer_state_t state_reg;
  spi_fifo_pkg::xfer_state_t state_next;

  logic sys_en, master, idle_lvl, phase, soe, lsbf;
  logic single, halt_wait, bidir_oe, fault_en, word16, fifo_en;
  logic clk_en, master_run, tick, fault_in, slave_sel;
  logic sck_s, mosi_s, miso_s, ss_s;
  logic lead_ev, trail_ev, sample_ev, drive_ev, din;
  logic start_ok, finish_m, finish_s, abort;
  logic [4:0] bits, cnt_now;
  logic [15:0] rx_word;
  logic [7:0] status;
  logic wr_data_low, rd_data_low;

  spi_queue_if #(.W(spi_fifo_pkg::WORD_W), .CW(spi_fifo_pkg::QUEUE_CW)) txq ();
  spi_queue_if #(.W(spi_fifo_pkg::WORD_W), .CW(spi_fifo_pkg::QUEUE_CW)) rxq ();

  assign sys_en = ctrl1_reg[spi_fifo_pkg::C1_SYS_EN];
  assign master = ctrl1_reg[spi_fifo_pkg::C1_MASTER];
  assign idle_lvl = ctrl1_reg[spi_fifo_pkg::C1_IDLE_LEVEL];
  assign phase = ctrl1_reg[spi_fifo_pkg::C1_PHASE];
  assign soe = ctrl1_reg[spi_fifo_pkg::C1_SEL_OUT_EN];
  assign lsbf = ctrl1_reg[spi_fifo_pkg::C1_LSB_FIRST];
  assign single = ctrl2_reg[spi_fifo_pkg::C2_SINGLE_WIRE];
  assign halt_wait = ctrl2_reg[spi_fifo_pkg::C2_HALT_WAIT];
  assign bidir_oe = ctrl2_reg[spi_fifo_pkg::C2_BIDIR_OE];
  assign fault_en = ctrl2_reg[spi_fifo_pkg::C2_FAULT_EN];
  assign word16 = ctrl2_reg[spi_fifo_pkg::C2_WORD16];
  assign fifo_en = ctrl2_reg[spi_fifo_pkg::C2_FIFO_EN];

  // module clock: gate bit and deep stop
  assign clk_en = clk_gate_reg && !stop_deep_i;
  // clock generation halts in wait (optional) and light stop
  assign master_run = clk_en && !(wait_mode_i && halt_wait) && !stop_light_i;
  assign bits = word16 ? spi_fifo_pkg::BITS_LONG : spi_fifo_pkg::BITS_SHORT;

  spi_sync #(.W(4)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({sck_i, mosi_i, miso_i, ss_n_i}),
    .sync_o({sck_s, mosi_s, miso_s, ss_s})
  );

  spi_queue #(.WIDTH(spi_fifo_pkg::WORD_W), .DEPTH(spi_fifo_pkg::QUEUE_DEPTH)) u_txq (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(clk_en),
    .q(txq)
  );

  spi_queue #(.WIDTH(spi_fifo_pkg::WORD_W), .DEPTH(spi_fifo_pkg::QUEUE_DEPTH)) u_rxq (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(clk_en),
    .q(rxq)
  );

  // queue depth: one word double buffer, or eight bytes
  always_comb begin
    if (!fifo_en) begin
      txq.limit = spi_fifo_pkg::LIMIT_SINGLE;
    end else if (word16) begin
      txq.limit = spi_fifo_pkg::LIMIT_WORDS;
    end else begin
      txq.limit = spi_fifo_pkg::LIMIT_BYTES;
    end
  end
  assign rxq.limit = txq.limit;

  assign wr_data_low = reg_wr_i && reg_addr_i == spi_fifo_pkg::OFF_DATA_LOW;
  assign rd_data_low = reg_rd_i && reg_addr_i == spi_fifo_pkg::OFF_DATA_LOW;
  assign txq.push = wr_data_low && sys_en;
  assign txq.push_data = {word16 ? tx_high_reg : 8'h00, reg_wdata_i};
  assign txq.pop = state_reg == spi_fifo_pkg::XFER_IDLE && start_ok && !txq.empty;
  assign txq.flush = !sys_en;
  assign rxq.push = state_reg == spi_fifo_pkg::XFER_FINISH;
  assign rxq.push_data = rx_word;
  assign rxq.pop = rd_data_low;
  assign rxq.flush = !sys_en;

  // slave selection and mode fault input
  assign slave_sel = sys_en && !master && !ss_s;
  assign fault_in = sys_en && master && fault_en && !soe && !ss_s;

  // edge events: master from divider ticks, slave from the pin
  assign tick = master_run && state_reg == spi_fifo_pkg::XFER_SHIFT && master && baud_cnt_reg == baud_reg;
  always_comb begin
    if (master) begin
      lead_ev = tick && !half_reg;
      trail_ev = tick && half_reg;
    end else begin
      lead_ev = slave_sel && sck_s != sck_d_reg && sck_s != idle_lvl;
      trail_ev = slave_sel && sck_s != sck_d_reg && sck_s == idle_lvl;
    end
  end
  assign sample_ev = state_reg == spi_fifo_pkg::XFER_SHIFT && (phase ? trail_ev : lead_ev);
  assign drive_ev = state_reg == spi_fifo_pkg::XFER_SHIFT && (phase ? lead_ev : trail_ev);
  assign cnt_now = bit_cnt_reg + {4'h0, sample_ev};

  // shifter input pin per mode
  always_comb begin
    if (master) begin
      din = single ? mosi_s : miso_s;
    end else begin
      din = single ? miso_s : mosi_s;
    end
  end

  // transfer sequencing
  assign start_ok = clk_en && sys_en && (master ? (!txq.empty && !fault_in) : slave_sel);
  assign finish_m = master && trail_ev && cnt_now == bits;
  assign finish_s = !master && sample_ev && cnt_now == bits;
  assign abort = master ? fault_in : !slave_sel;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      spi_fifo_pkg::XFER_IDLE: begin
        if (start_ok) begin
          state_next = spi_fifo_pkg::XFER_SHIFT;
        end
      end
      spi_fifo_pkg::XFER_SHIFT: begin
        if (abort) begin
          state_next = spi_fifo_pkg::XFER_IDLE;
        end else if (finish_m || finish_s) begin
          state_next = spi_fifo_pkg::XFER_FINISH;
        end
      end
      spi_fifo_pkg::XFER_FINISH: begin
        state_next = spi_fifo_pkg::XFER_IDLE;
      end
      default: begin
        state_next = spi_fifo_pkg::XFER_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= spi_fifo_pkg::XFER_IDLE;
    end else if (stop_deep_i || !sys_en) begin
      state_reg <= spi_fifo_pkg::XFER_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // received word, aligned to the low bits in 8-bit mode
  always_comb begin
    if (word16) begin
      rx_word = rx_sr_reg;
    end else if (lsbf) begin
      rx_word = {8'h00, rx_sr_reg[15:8]};
    end else begin
      rx_word = {8'h00, rx_sr_reg[7:0]};
    end
  end

  function automatic logic first_bit(input logic [15:0] v, input logic lsb, input logic w16);
    first_bit = lsb ? v[0] : (w16 ? v[15] : v[7]);
  endfunction

  function automatic logic [15:0] shift_out(input logic [15:0] v, input logic lsb);
    shift_out = lsb ? {1'b0, v[15:1]} : {v[14:0], 1'b0};
  endfunction

  // shift registers: load, drive and sample
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sr_reg <= '0;
      rx_sr_reg <= '0;
      out_bit_reg <= 1'b0;
      bit_cnt_reg <= '0;
    end else if (stop_deep_i) begin
      tx_sr_reg <= '0;
      rx_sr_reg <= '0;
      out_bit_reg <= 1'b0;
      bit_cnt_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == spi_fifo_pkg::XFER_IDLE && start_ok) begin
        bit_cnt_reg <= '0;
        out_bit_reg <= first_bit(txq.empty ? 16'h0000 : txq.head, lsbf, word16);
        if (phase) begin
          tx_sr_reg <= txq.empty ? 16'h0000 : txq.head;
        end else begin
          tx_sr_reg <= shift_out(txq.empty ? 16'h0000 : txq.head, lsbf);
        end
      end else begin
        if (drive_ev) begin
          out_bit_reg <= first_bit(tx_sr_reg, lsbf, word16);
          tx_sr_reg <= shift_out(tx_sr_reg, lsbf);
        end
        if (sample_ev) begin
          rx_sr_reg <= lsbf ? {din, rx_sr_reg[15:1]} : {rx_sr_reg[14:0], din};
          bit_cnt_reg <= cnt_now;
        end
      end
    end
  end

  // master bit-rate divider and serial clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_cnt_reg <= '0;
      half_reg <= 1'b0;
      sck_reg <= 1'b0;
      sck_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      sck_reg <= idle_lvl ^ half_reg;
      if (stop_deep_i || state_reg != spi_fifo_pkg::XFER_SHIFT) begin
        baud_cnt_reg <= '0;
        half_reg <= 1'b0;
      end else if (master_run) begin
        baud_cnt_reg <= tick ? 8'h00 : baud_cnt_reg + 8'h01;
        if (tick) begin
          half_reg <= !half_reg;
        end
      end
    end
  end

  // automatic select output: low while a transfer runs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_out_reg <= 1'b1;
    end else begin
      ss_out_reg <= state_next == spi_fifo_pkg::XFER_IDLE || !clk_en || !sys_en;
    end
  end

  // pin routing
  assign sck_o = sck_reg;
  assign mosi_o = out_bit_reg;
  assign miso_o = out_bit_reg;
  assign ss_n_o = ss_out_reg;
  assign sck_oe_n_o = !(sys_en && master);
  assign mosi_oe_n_o = !(sys_en && master && (!single || bidir_oe));
  assign miso_oe_n_o = !(sys_en && !master && (single ? bidir_oe : slave_sel));
  assign ss_n_oe_n_o = !(sys_en && master && fault_en && soe);
  assign pin_owned_o[0] = sys_en;
  assign pin_owned_o[1] = sys_en && (master || !single);
  assign pin_owned_o[2] = sys_en && (!master || !single);
  assign pin_owned_o[3] = sys_en && (!master || fault_en);

  // registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl1_reg <= spi_fifo_pkg::CTRL1_RST;
      ctrl2_reg <= spi_fifo_pkg::CTRL2_RST;
      baud_reg <= spi_fifo_pkg::BAUD_RST;
      clk_gate_reg <= spi_fifo_pkg::GATE_RST;
      tx_high_reg <= 8'h00;
    end else if (stop_deep_i) begin
      ctrl1_reg <= spi_fifo_pkg::CTRL1_RST;
      ctrl2_reg <= spi_fifo_pkg::CTRL2_RST;
      baud_reg <= spi_fifo_pkg::BAUD_RST;
      clk_gate_reg <= spi_fifo_pkg::GATE_RST;
      tx_high_reg <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == spi_fifo_pkg::OFF_CLK_GATE) begin
        clk_gate_reg <= reg_wdata_i[0];
      end
      if (clk_gate_reg) begin
        case (reg_addr_i)
          spi_fifo_pkg::OFF_CTRL1: ctrl1_reg <= reg_wdata_i;
          spi_fifo_pkg::OFF_CTRL2: ctrl2_reg <= {reg_wdata_i[7:6], 1'b0, reg_wdata_i[4:3], 1'b0, reg_wdata_i[1:0]};
          spi_fifo_pkg::OFF_BAUD: baud_reg <= reg_wdata_i;
          spi_fifo_pkg::OFF_DATA_HIGH: tx_high_reg <= reg_wdata_i;
          default: ;
        endcase
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else if (stop_deep_i || !sys_en) begin
      fault_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else if (clk_en) begin
      if (fault_in) begin
        fault_reg <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == spi_fifo_pkg::OFF_STATUS && reg_wdata_i[spi_fifo_pkg::ST_FAULT]) begin
        fault_reg <= 1'b0;
      end
      if (rxq.push && rxq.full) begin
        overrun_reg <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == spi_fifo_pkg::OFF_STATUS && reg_wdata_i[spi_fifo_pkg::ST_RXQ_OVR]) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    status = 8'h00;
    status[spi_fifo_pkg::ST_RX_READY] = sys_en && !rxq.empty;
    status[spi_fifo_pkg::ST_TX_ROOM] = sys_en && !txq.full;
    status[spi_fifo_pkg::ST_FAULT] = fault_reg;
    status[spi_fifo_pkg::ST_RXQ_FULL] = sys_en && fifo_en && rxq.full;
    status[spi_fifo_pkg::ST_TXQ_FULL] = sys_en && fifo_en && txq.full;
    status[spi_fifo_pkg::ST_RXQ_OVR] = overrun_reg;
  end

  // read data, valid in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        spi_fifo_pkg::OFF_CTRL1: reg_rdata_o <= ctrl1_reg;
        spi_fifo_pkg::OFF_CTRL2: reg_rdata_o <= ctrl2_reg;
        spi_fifo_pkg::OFF_BAUD: reg_rdata_o <= baud_reg;
        spi_fifo_pkg::OFF_STATUS: reg_rdata_o <= status;
        spi_fifo_pkg::OFF_DATA_HIGH: reg_rdata_o <= word16 ? rxq.head[15:8] : 8'h00;
        spi_fifo_pkg::OFF_DATA_LOW: reg_rdata_o <= rxq.head[7:0];
        spi_fifo_pkg::OFF_CLK_GATE: reg_rdata_o <= {7'h00, clk_gate_reg};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // checks
  a_gate_deep_wake: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    stop_deep_i |=> clk_gate_reg && ctrl1_reg == spi_fifo_pkg::CTRL1_RST && ctrl2_reg == spi_fifo_pkg::CTRL2_RST)
    else $error("deep stop did not restore reset values");
  a_wait_halt_freeze: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (master && wait_mode_i && halt_wait && state_reg == spi_fifo_pkg::XFER_SHIFT && !stop_deep_i)
    |=> $stable(half_reg) && $stable(bit_cnt_reg))
    else $error("master moved while halted in wait");
  a_light_stop_pause: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (master && stop_light_i && state_reg == spi_fifo_pkg::XFER_SHIFT) |=> $stable(tx_sr_reg))
    else $error("master shifted in light stop");
  a_slave_unselected: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!master && ss_s && state_reg == spi_fifo_pkg::XFER_IDLE) |=> state_reg == spi_fifo_pkg::XFER_IDLE)
    else $error("slave started without select");
  a_word_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg == spi_fifo_pkg::XFER_FINISH |-> bit_cnt_reg == bits ##1 state_reg == spi_fifo_pkg::XFER_IDLE)
    else $error("word stored at wrong bit count");
  a_disable_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !sys_en |=> state_reg == spi_fifo_pkg::XFER_IDLE && !fault_reg && !overrun_reg)
    else $error("disabled block not idle");
  a_pins_released: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !sys_en |-> pin_owned_o == 4'h0 && sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o && ss_n_oe_n_o)
    else $error("pin driven while disabled");
  a_single_master: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sys_en && master && single) |-> mosi_oe_n_o == !bidir_oe && miso_oe_n_o && !pin_owned_o[2])
    else $error("single-wire master pin routing wrong");
  a_single_slave: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sys_en && !master && single) |-> mosi_oe_n_o && !pin_owned_o[1] && miso_oe_n_o == !bidir_oe)
    else $error("single-wire slave pin routing wrong");
  a_duplex_master: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sys_en && master && !single) |-> !mosi_oe_n_o && miso_oe_n_o && !sck_oe_n_o)
    else $error("full-duplex master routing wrong");
  a_select_fault_in: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (sys_en && master && fault_en && !soe) |-> ss_n_oe_n_o && pin_owned_o[3])
    else $error("fault input driven");
endmodule

// *** test/spi_far_slave.sv ***
// behavioural remote spi slave, clock idles low, sample on leading edge
`timescale 1ns/1ps
module spi_far_slave (
  // link pins, reply word and captured word
  input wire logic sck_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic [7:0] reply_i,
  output logic miso_o,
  output logic [7:0] got_o
);
  logic [7:0] sh;
  initial miso_o = 1'b1;
  always @(negedge ss_n_i) begin
    sh = reply_i;
    miso_o = sh[7];
  end
  always @(posedge sck_i) if (!ss_n_i) got_o = {got_o[6:0], mosi_i};
  always @(negedge sck_i) if (!ss_n_i) begin
    sh = sh << 1;
    miso_o = sh[7];
  end
  // released line shows the inverse of its last bit
  always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule

// *** test/spi_fifo_ctrl_test.sv ***
// self-checking bench for the fifo spi block
`timescale 1ns/1ps
module spi_fifo_ctrl_test;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stop_d = 1'b0;
  logic wait_m = 1'b0;
  logic stop_l = 1'b0;
  logic [7:0] rdata, rv, got;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_o, ss_oe_n, far_miso;
  logic [3:0] owned;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  wire sck_pin = sck_oe_n ? 1'b0 : sck_o;
  wire mosi_pin = mosi_oe_n ? 1'b0 : mosi_o;
  wire miso_pin = miso_oe_n ? far_miso : miso_o;
  wire ss_pin = ss_oe_n ? 1'b1 : ss_o;
  spi_fifo_ctrl spi_fifo_ctrl_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .wait_mode_i(wait_m),
    .stop_light_i(stop_l), .stop_deep_i(stop_d), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n),
    .mosi_i(mosi_pin), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_pin), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n), .ss_n_i(ss_pin), .ss_n_o(ss_o), .ss_n_oe_n_o(ss_oe_n), .pin_owned_o(owned));
  spi_far_slave spi_far_slave_i (.sck_i(sck_pin), .ss_n_i(ss_pin), .mosi_i(mosi_pin), .reply_i(8'h3C),
    .miso_o(far_miso), .got_o(got));
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("MISMATCH %0t timeout", $time);
      conclude();
    end
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge sys_clk_i); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_i); addr <= a; rd <= 1'b1;
    @(posedge sys_clk_i); rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
    rd_reg(a, rv);
    chk(rv, e);
  endtask
  // owned: {ss,miso,mosi,sck}; oe_n: {sck,mosi,miso,ss}
  task automatic chk_pins(input logic [3:0] eo, input logic [3:0] en);
    @(posedge sys_clk_i); #1;
    chk({4'h0, owned}, {4'h0, eo});
    chk({4'h0, sck_oe_n, mosi_oe_n, miso_oe_n, ss_oe_n}, {4'h0, en});
  endtask
  task automatic t_reset();
    chk_reg(spi_fifo_pkg::OFF_CLK_GATE, 8'h01);
    chk_reg(spi_fifo_pkg::OFF_CTRL1, spi_fifo_pkg::CTRL1_RST);
    chk_pins(4'h0, 4'hF);
  endtask
  task automatic t_exchange();
    wr_reg(spi_fifo_pkg::OFF_CTRL2, 8'h12);
    wr_reg(spi_fifo_pkg::OFF_BAUD, 8'h03);
    wr_reg(spi_fifo_pkg::OFF_CTRL1, 8'h52);
    chk_pins(4'hF, 4'h2);
    wr_reg(spi_fifo_pkg::OFF_DATA_LOW, 8'hA5);
    // master freezes in halted wait, then in light stop, then resumes
    @(posedge sys_clk_i);
    wait_m <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    wait_m <= 1'b0;
    stop_l <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    stop_l <= 1'b0;
    rv = 8'h00;
    for (int i = 0; i < 300 && rv[0] !== 1'b1; i++) rd_reg(spi_fifo_pkg::OFF_STATUS, rv);
    chk_reg(spi_fifo_pkg::OFF_DATA_LOW, 8'h3C);
    chk(got, 8'hA5);
  endtask
  task automatic t_single_wire();
    wr_reg(spi_fifo_pkg::OFF_CTRL2, 8'h19);
    chk_pins(4'hB, 4'h2);
    wr_reg(spi_fifo_pkg::OFF_CTRL2, 8'h11);
    chk_pins(4'hB, 4'h6);
    wr_reg(spi_fifo_pkg::OFF_CTRL1, 8'h40);
    chk_pins(4'hD, 4'hF);
    wr_reg(spi_fifo_pkg::OFF_CTRL1, 8'h00);
    chk_pins(4'h0, 4'hF);
    rd_reg(spi_fifo_pkg::OFF_STATUS, rv);
    chk(rv, 8'h00);
  endtask
  task automatic t_deep();
    wr_reg(spi_fifo_pkg::OFF_CTRL2, 8'h40);
    wr_reg(spi_fifo_pkg::OFF_CLK_GATE, 8'h00);
    wr_reg(spi_fifo_pkg::OFF_CTRL2, 8'h01);
    chk_reg(spi_fifo_pkg::OFF_CTRL2, 8'h40);
    @(posedge sys_clk_i);
    stop_d <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    stop_d <= 1'b0;
    chk_reg(spi_fifo_pkg::OFF_CTRL2, spi_fifo_pkg::CTRL2_RST);
    chk_reg(spi_fifo_pkg::OFF_CLK_GATE, 8'h01);
  endtask
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_exchange();
    t_single_wire();
    t_deep();
    conclude();
  end
endmodule
